// >>> verif/i2cie_bus_peer.sv
// i2cie_bus_peer: far party of the acknowledge slot, with its link clock.
// assumes: the bench calls run and slot; data line has a pull-up.
`timescale 1ns/10ps
`default_nettype none
module i2cie_bus_peer (
   output logic link_clk, // link clock, still between frames
   output logic link_ack_slot, // ninth-bit window
   output logic link_tx_mode, // high when device transmits
   output logic sda_in, // resolved data line
   input wire logic sda_out, // device drive value
   input wire logic sda_oe_n, // device drives when low
   output logic seen_ack // line level at the slot end
);
   logic pull_low; // peer pulls the line low
   // open-drain wire: low if any party pulls low, else pull-up
   assign sda_in = !(pull_low || (!sda_oe_n && !sda_out));
   initial begin
      link_clk = 1'b0;
      link_ack_slot = 1'b0;
      link_tx_mode = 1'b0;
      pull_low = 1'b0;
      seen_ack = 1'b0;
   end
   // clock runs only here, so it stands still outside frames
   task run(input int n);
      repeat (n) begin
         #16 link_clk = 1'b1;
         #16 link_clk = 1'b0;
      end
   endtask : run
   // one slot; a transmitting device hears our ack, otherwise we listen
   task slot(input logic tx, input logic ack);
      #5 link_tx_mode = tx;
      link_ack_slot = 1'b1;
      pull_low = tx & !ack;
      run(6);
      seen_ack = sda_in;
      link_ack_slot = 1'b0;
      pull_low = 1'b0;
      run(6);
   endtask : slot
endmodule : i2cie_bus_peer
`default_nettype wire

// >>> verif/i2cie_ctrl_properties.sv
// i2cie_ctrl_properties: port-level timing checks of the control block.
// assumes: bound to i2cie_ctrl; only the module clock domain is watched.
`timescale 1ns/10ps
`default_nettype none
module i2cie_ctrl_properties (
   input wire logic clock, // module clock
   input wire logic sys_rst, // sync reset, high
   input wire logic [3:0] reg_addr, // register index
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire i2cie_pkg::i2cie_flags_t flags, // status flags
   input wire logic sync_format, // synchronous format
   input wire i2cie_pkg::i2cie_irq_t irq, // request lines
   input wire logic tx_end_set, // end pulse
   input wire logic no_ack_set, // no-ack pulse
   input wire logic transfer_halt, // halt level
   input wire logic ack_judge_select // judge level
);
   logic [7:0] en; // shadow of the enable register
   // shadow follows writes; bit 1 comes from the link, so it is not used
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         en <= 8'h00;
      end else begin
         if (reg_wr && reg_addr == i2cie_pkg::IER_OFFSET) begin
            en <= reg_wdata;
         end
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // pulses last one cycle; a no-ack pulse only while judging
   // the select is looked at one cycle back, where the pulse was decided,
   // so a write that clears it in that same cycle is no false alarm
   sequence s_nak_pulse; $past(ack_judge_select) ##1 !no_ack_set; endsequence
   sequence s_end_pulse; tx_end_set ##1 !tx_end_set; endsequence
   a_tx_empty_gate:
      assert property (irq.tx_empty_irq == (flags.tx_empty_flag && en[7]))
      else $error("tx empty request mismatch");
   a_tx_end_gate:
      assert property (irq.tx_end_irq == (flags.tx_end_flag && en[6]))
      else $error("tx end request mismatch");
   a_rx_full_gate:
      assert property (irq.rx_full_irq == (flags.rx_full_flag && en[5]))
      else $error("rx full request mismatch");
   a_error_gate:
      assert property (irq.error_irq == (sync_format && flags.overrun_flag && (en[5] || en[4])))
      else $error("error request mismatch");
   a_no_ack_gate:
      assert property (irq.no_ack_irq == (en[4] && (flags.no_ack_flag
         || flags.arbitration_lost_flag || (sync_format && flags.overrun_flag))))
      else $error("no-ack request mismatch");
   a_stop_gate:
      assert property (irq.stop_detect_irq == (flags.stop_flag && en[3]))
      else $error("stop request mismatch");
   a_judge_follow:
      assert property (ack_judge_select == en[2])
      else $error("judge select not following register");
   a_halt_drop:
      assert property ($fell(ack_judge_select) |-> ##[0:1] !transfer_halt)
      else $error("halt kept without judging");
   a_halt_judged:
      assert property ($rose(transfer_halt) |-> $past(ack_judge_select))
      else $error("halt raised without judging");
   a_nak_judged:
      assert property (no_ack_set |-> s_nak_pulse)
      else $error("bad no-ack pulse");
   a_end_pulse:
      assert property (tx_end_set |-> s_end_pulse)
      else $error("tx end pulse too long");
endmodule : i2cie_ctrl_properties
bind i2cie_ctrl i2cie_ctrl_properties i_i2cie_ctrl_properties (.clock, .sys_rst,
   .reg_addr, .reg_wdata, .reg_wr, .flags, .sync_format, .irq, .tx_end_set,
   .no_ack_set, .transfer_halt, .ack_judge_select);
`default_nettype wire

// >>> verif/testbench.sv
// testbench: register port, request gating and acknowledge slot checks.
// assumes: i2cie_ctrl and the peer model; 4 ns clock, 32 ns link clock.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clock, sys_rst, link_clk, link_ack_slot, link_tx_mode, sda_in;
   logic sda_out, sda_oe_n, reg_wr, reg_rd, sync_format, seen_ack;
   logic tx_end_set, no_ack_set, transfer_halt, ack_judge_select;
   logic [3:0] reg_addr; // register index driven
   logic [7:0] reg_wdata, reg_rdata, en_m; // en_m: model of the register
   logic [31:0] r; // random word
   logic [2:0] tb [3] = '{3'b111, 3'b101, 3'b010}; // {judge, ack, tx empty}
   i2cie_pkg::i2cie_flags_t flags; // status flags driven
   i2cie_pkg::i2cie_irq_t irq; // requests seen
   int bad_count, samples_checked, cycles, te_cnt, na_cnt, te0, na0, seed, i, j, k;
   i2cie_ctrl i_i2cie_ctrl (.clock, .sys_rst, .link_clk, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .flags, .sync_format, .irq, .tx_end_set,
      .no_ack_set, .transfer_halt, .ack_judge_select, .link_ack_slot,
      .link_tx_mode, .sda_in, .sda_out, .sda_oe_n);
   i2cie_bus_peer i_i2cie_bus_peer (.link_clk, .link_ack_slot, .link_tx_mode,
      .sda_in, .sda_out, .sda_oe_n, .seen_ack);
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // pulse counters and the hang guard
   always @(posedge clock) begin
      cycles++;
      if (tx_end_set === 1'b1) te_cnt++;
      if (no_ack_set === 1'b1) na_cnt++;
      if (cycles == 6000) begin
         bad_count++;
         give_verdict();
      end
   end
   // expected requests: each is its cause gated by its enable
   function automatic logic [5:0] irq_exp(logic [6:0] f, logic s, logic [7:0] e);
      return {f[6] & e[7], f[5] & e[6], f[4] & e[5], s & f[1] & (e[5] | e[4]),
         e[4] & (f[3] | f[2] | (s & f[1])), f[0] & e[3]};
   endfunction : irq_exp
   task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, seen);
         bad_count++;
      end
   endtask : check
   task wr(input logic [3:0] a, input logic [7:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task rd(input logic [3:0] a, input logic [7:0] exp, input string name);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 check(name, reg_rdata, exp);
      @(posedge clock);
   endtask : rd
   task give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   initial begin
      seed = 50;
      sys_rst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      flags = '0;
      sync_format = 1'b0;
      // reset spans a few link edges so the link side is cleared too
      i_i2cie_bus_peer.run(4);
      @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      check("idle drive", {6'h00, sda_oe_n, sda_out}, 8'h03);
      rd(4'h0, 8'h00, "enable reset");
      wr(4'h1, 8'hff);
      rd(4'h1, 8'h00, "status");
      wr(4'h5, 8'hff);
      rd(4'h5, 8'h00, "unmapped");
      $display("test registers done");
      // random enables and flags; bit 1 writes must not stick
      for (j = 0; j < 8; j++) begin
         r = $random(seed);
         wr(4'h0, r[7:0]);
         en_m = r[7:0] & 8'hfd;
         rd(4'h0, en_m, "enable");
         for (i = 0; i < 24; i++) begin
            r = $random(seed);
            {flags, sync_format} <= r[7:0];
            #1 check("irq", {2'b00, irq}, {2'b00, irq_exp(flags, sync_format, en_m)});
            @(posedge clock);
         end
      end
      $display("test requests done");
      // transmit slots: judge on/off, ack 1/0, tx empty on/off
      for (k = 0; k < 3; k++) begin
         flags <= {tb[k][0], 6'b000000};
         sync_format <= 1'b0;
         wr(4'h0, {5'b00000, tb[k][2], 2'b00});
         te0 = te_cnt;
         na0 = na_cnt;
         i_i2cie_bus_peer.slot(1'b1, tb[k][1]);
         repeat (12) @(posedge clock);
         check("tx end pulses", 8'(te_cnt - te0), {7'h00, tb[k][0]});
         check("no-ack pulses", 8'(na_cnt - na0), {7'h00, tb[k][2] & tb[k][1]});
         check("halt", {7'h00, transfer_halt}, {7'h00, tb[k][2] & tb[k][1]});
         rd(4'h0, {5'b00000, tb[k][2], tb[k][1], 1'b0}, "received ack");
      end
      // clocked format has no ack slot: a slot there must change nothing
      flags <= 7'h40;
      sync_format <= 1'b1;
      te0 = te_cnt;
      na0 = na_cnt;
      i_i2cie_bus_peer.slot(1'b1, 1'b0);
      repeat (12) @(posedge clock);
      check("sync slot end pulses", 8'(te_cnt - te0), 8'h00);
      check("sync slot no-ack pulses", 8'(na_cnt - na0), 8'h00);
      sync_format <= 1'b0;
      rd(4'h0, 8'h02, "sync keeps ack");
      rd(4'h1, 8'h06, "status");
      $display("test transmit slots done");
      // receive slots: bit 0 goes on the line, received ack is kept
      for (k = 0; k < 2; k++) begin
         wr(4'h0, 8'(k));
         i_i2cie_bus_peer.slot(1'b0, 1'b1);
         @(posedge clock);
         check("ack sent", {7'h00, seen_ack}, 8'(k));
         check("released", {7'h00, sda_oe_n}, 8'h01);
         rd(4'h0, 8'h02 | 8'(k), "receive keeps ack");
      end
      $display("test receive slots done");
      give_verdict();
   end
endmodule : testbench
`default_nettype wire

// >>> verilog/i2cie_ack_link.sv
// i2cie_ack_link: link-clock side of the acknowledge slot.
// assumes: link_ack_slot and link_tx_mode come from the shift engine on
// link_clk; sda_in comes from the pin; ack_send comes from the clock domain.
`timescale 1ns/10ps
`default_nettype none
module i2cie_ack_link (
   input wire logic link_clk,                 // bus clock of the link
   input wire logic sys_rst,                  // reset from the clock domain
   input wire logic ack_send,                 // ack level to drive, other domain
   input wire logic link_ack_slot,            // high through the ninth bit
   input wire logic link_tx_mode,             // high while transmitting
   input wire logic sda_in,                   // data line level
   output logic sda_out,                      // data line drive value
   output logic sda_oe_n,                     // low while driving data line
   output logic ack_toggle,                   // flips once per ack slot
   output i2cie_pkg::i2cie_ack_t ack_word     // stable until next flip
);

   // whole state of the link side
   typedef struct packed {
      logic rst_meta;
      logic rst_sync;
      logic send_meta;
      logic send_sync;
      logic sda_meta;
      logic sda_sync;
      logic slot_d1;
      logic slot_d2;
      logic tx_d1;
      logic tx_d2;
      logic slot_last;
      logic toggle;
      i2cie_pkg::i2cie_ack_t word;
      logic drv;
      logic drv_oe_n;
   } i2cie_link_state_t;

   i2cie_link_state_t st;
   i2cie_link_state_t next_st;

   // next state; the pin and slot are delayed alike so they stay aligned
   always_comb begin
      next_st = st;
      next_st.rst_meta = sys_rst;
      next_st.rst_sync = st.rst_meta;
      next_st.send_meta = ack_send;
      next_st.send_sync = st.send_meta;
      next_st.sda_meta = sda_in;
      next_st.sda_sync = st.sda_meta;
      next_st.slot_d1 = link_ack_slot;
      next_st.slot_d2 = st.slot_d1;
      next_st.tx_d1 = link_tx_mode;
      next_st.tx_d2 = st.tx_d1;
      next_st.slot_last = st.slot_d2;
      if (st.slot_d2 && !st.slot_last) begin
         next_st.word.ack_value = st.sda_sync;
         next_st.word.tx_mode = st.tx_d2;
         next_st.toggle = ~st.toggle;
      end
      if (link_ack_slot && !link_tx_mode) begin
         next_st.drv = st.send_sync;
         next_st.drv_oe_n = 1'b0;
      end else begin
         next_st.drv = 1'b1;
         next_st.drv_oe_n = 1'b1;
      end
      // reset is caught through its own two flops first
      if (st.rst_sync) begin
         next_st.send_meta = 1'b0;
         next_st.send_sync = 1'b0;
         next_st.slot_d1 = 1'b0;
         next_st.slot_d2 = 1'b0;
         next_st.tx_d1 = 1'b0;
         next_st.tx_d2 = 1'b0;
         next_st.slot_last = 1'b0;
         next_st.toggle = 1'b0;
         next_st.word = '0;
         next_st.drv = 1'b1;
         next_st.drv_oe_n = 1'b1;
      end
   end

   // register the state
   always_ff @(posedge link_clk) begin
      st <= next_st;
   end

   assign sda_out = st.drv;
   assign sda_oe_n = st.drv_oe_n;
   assign ack_toggle = st.toggle;
   assign ack_word = st.word;

endmodule : i2cie_ack_link
`default_nettype wire

// >>> verilog/i2cie_ctrl.sv
// i2cie_ctrl: interrupt-enable and acknowledge control of the two-wire
// serial interface, with the enable register and the ack slot logic.
// assumes: status flags arrive on clock from the status logic; the shift
// engine gives ack slot and transmit mode on link_clk; the register port
// master is on clock and never issues both strobes at once.
//
// Function
// - transmit-empty request needs enable bit 7
// - transmit-end on ninth clock, enable bit 6
// - transmit-end request drops with flag or enable
// - receive-full request needs bit 5, overrun request bit 5 or bit 4
// - receive-full request drops with flag or enable
// - no-ack or arbitration-lost request needs bit 4
// - no-ack request drops when cause cleared
// - stop request needs enable bit 3
// - judge select 0 ignores received ack
// - judge select 1 halts on ack 1
// - received ack captured, read-only bit 1
// - bit 0 driven in receive ack slot
// - no-ack set only when judging in transmit
`timescale 1ns/10ps
`default_nettype none
module i2cie_ctrl (
   input wire logic clock,                        // module clock, 250 MHz
   input wire logic sys_rst,                      // synchronous reset, high
   input wire logic link_clk,                     // bus clock of the link
   input wire logic [3:0] reg_addr,               // register index
   input wire logic [7:0] reg_wdata,              // write data
   input wire logic reg_wr,                       // write strobe
   input wire logic reg_rd,                       // read strobe
   output logic [7:0] reg_rdata,                  // read data, next cycle
   input wire i2cie_pkg::i2cie_flags_t flags,     // status flags
   input wire logic sync_format,                  // clocked synchronous format
   output i2cie_pkg::i2cie_irq_t irq,             // interrupt requests
   output logic tx_end_set,                       // pulse: set transmit end
   output logic no_ack_set,                       // pulse: set no-ack flag
   output logic transfer_halt,                    // stop continuous transfer
   output logic ack_judge_select,                 // judge select to engine
   input wire logic link_ack_slot,                // ack slot, on link_clk
   input wire logic link_tx_mode,                 // transmit mode, link_clk
   input wire logic sda_in,                       // data line level
   output logic sda_out,                          // data line drive value
   output logic sda_oe_n                          // low while driving
);

   // whole state of the clock side
   typedef struct packed {
      logic [7:0] ier;          // enable register, bit 1 holds received ack
      logic [7:0] rdata;        // read data register
      logic tog_meta;           // first flop of toggle crossing
      logic tog_sync;           // second flop of toggle crossing
      logic tog_last;           // previous synced toggle for edge
      logic last_tx;            // mode of the last ack slot
      logic halt;               // continuous transfer halted
      logic tx_end_pulse;       // transmit end set request
      logic no_ack_pulse;       // no-ack set request
   } i2cie_ctrl_state_t;

   i2cie_ctrl_state_t st;
   i2cie_ctrl_state_t next_st;

   // request bundle, grouped for decoding
   i2cie_pkg::i2cie_req_t req;

   // ack word and its event toggle from the link side
   logic ack_toggle;
   i2cie_pkg::i2cie_ack_t ack_word;

   // one new ack slot seen on the clock side
   logic ack_event;

   // write and read hits per register
   logic wr_ier;
   logic rd_ier;
   logic rd_status;

   // status register image
   logic [7:0] status_img;

   // link side: sampling, capture and drive of the ack bit
   i2cie_ack_link u_link (
      .link_clk(link_clk),
      .sys_rst(sys_rst),
      .ack_send(st.ier[i2cie_pkg::ACK_SEND_BIT]),
      .link_ack_slot(link_ack_slot),
      .link_tx_mode(link_tx_mode),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe_n(sda_oe_n),
      .ack_toggle(ack_toggle),
      .ack_word(ack_word)
   );

   // address match, used for write and for read decode
   function automatic logic addr_hit(
      input logic [3:0] addr,
      input logic [3:0] offset
   );
      addr_hit = (addr == offset);
   endfunction : addr_hit

   // gather the port into the request carrier
   always_comb begin
      req.addr = reg_addr;
      req.wdata = reg_wdata;
      req.wr = reg_wr;
      req.rd = reg_rd;
   end

   // decode strobes against the map
   always_comb begin
      wr_ier = 1'b0;
      rd_ier = 1'b0;
      rd_status = 1'b0;
      if (addr_hit(req.addr, i2cie_pkg::IER_OFFSET)) begin
         wr_ier = req.wr;
         rd_ier = req.rd;
      end else if (addr_hit(req.addr, i2cie_pkg::ACK_STATUS_OFFSET)) begin
         rd_status = req.rd;
      end
   end

   // the word is stable well before the toggle lands here, so reading it
   // on the synced edge is safe: ack slots are many link cycles apart
   assign ack_event = st.tog_sync ^ st.tog_last;

   // status image: halt, last ack value, mode of last slot
   always_comb begin
      status_img = i2cie_pkg::DATA_RESET;
      status_img[i2cie_pkg::HALT_BIT] = st.halt;
      status_img[i2cie_pkg::LAST_ACK_BIT] = st.ier[i2cie_pkg::RX_ACK_BIT];
      status_img[i2cie_pkg::LAST_TX_BIT] = st.last_tx;
   end

   // next state of the clock side
   always_comb begin
      next_st = st;
      // crossing of the link event; first flop feeds only the second
      next_st.tog_meta = ack_toggle;
      next_st.tog_sync = st.tog_meta;
      next_st.tog_last = st.tog_sync;
      // pulses last one cycle
      next_st.tx_end_pulse = 1'b0;
      next_st.no_ack_pulse = 1'b0;

      // software write; received ack bit is kept from the hardware
      if (wr_ier) begin
         next_st.ier = (req.wdata & i2cie_pkg::IER_WRITE_MASK)
                     | (st.ier & ~i2cie_pkg::IER_WRITE_MASK);
      end

      // the ack slot closes a byte; the clocked format has no ack slot
      if (ack_event && !sync_format) begin
         next_st.last_tx = ack_word.tx_mode;
         next_st.tx_end_pulse = flags.tx_empty_flag;
         if (ack_word.tx_mode) begin
            next_st.ier[i2cie_pkg::RX_ACK_BIT] = ack_word.ack_value;
            next_st.no_ack_pulse = ack_word.ack_value
                                 & st.ier[i2cie_pkg::ACK_JUDGE_BIT];
         end
      end

      // halt follows the judge select and the stored ack; clearing the
      // select resumes transfer, so software has a way out of a halt
      if (st.ier[i2cie_pkg::ACK_JUDGE_BIT]) begin
         next_st.halt = next_st.ier[i2cie_pkg::RX_ACK_BIT];
      end else begin
         next_st.halt = 1'b0;
      end

      // read data stand only in the cycle after the strobe
      if (rd_ier) begin
         next_st.rdata = st.ier;
      end else if (rd_status) begin
         next_st.rdata = status_img;
      end else begin
         // idle and unmapped reads answer zero
         next_st.rdata = i2cie_pkg::DATA_RESET;
      end

      // synchronous reset
      if (sys_rst) begin
         next_st.ier = i2cie_pkg::IER_RESET;
         next_st.rdata = i2cie_pkg::DATA_RESET;
         next_st.tog_meta = 1'b0;
         next_st.tog_sync = 1'b0;
         next_st.tog_last = 1'b0;
         next_st.last_tx = 1'b0;
         next_st.halt = 1'b0;
         next_st.tx_end_pulse = 1'b0;
         next_st.no_ack_pulse = 1'b0;
      end
   end

   // register the state
   always_ff @(posedge clock) begin
      st <= next_st;
   end

   // requests are gates, not latches, so they follow flag and enable
   // in the same cycle; the sticky part lives in the status flags
   always_comb begin
      irq.tx_empty_irq = flags.tx_empty_flag
                       & st.ier[i2cie_pkg::TX_EMPTY_EN_BIT];
      irq.tx_end_irq = flags.tx_end_flag
                     & st.ier[i2cie_pkg::TX_END_EN_BIT];
      irq.rx_full_irq = flags.rx_full_flag
                      & st.ier[i2cie_pkg::RX_FULL_EN_BIT];
      irq.error_irq = sync_format & flags.overrun_flag
                    & (st.ier[i2cie_pkg::RX_FULL_EN_BIT]
                       | st.ier[i2cie_pkg::NO_ACK_EN_BIT]);
      irq.no_ack_irq = st.ier[i2cie_pkg::NO_ACK_EN_BIT]
                     & (flags.no_ack_flag | flags.arbitration_lost_flag
                        | (sync_format & flags.overrun_flag));
      irq.stop_detect_irq = flags.stop_flag
                          & st.ier[i2cie_pkg::STOP_EN_BIT];
   end

   // outputs from registers
   assign reg_rdata = st.rdata;
   assign tx_end_set = st.tx_end_pulse;
   assign no_ack_set = st.no_ack_pulse;
   assign transfer_halt = st.halt;
   assign ack_judge_select = st.ier[i2cie_pkg::ACK_JUDGE_BIT];

endmodule : i2cie_ctrl
`default_nettype wire

// >>> verilog/i2cie_pkg.sv
// i2cie_pkg: constants and carrier types for the interrupt-enable and
// acknowledge-control block of the two-wire serial interface.
// assumes: every user writes i2cie_pkg::name, nothing is imported.
package i2cie_pkg;

   // register indices on the plain register port
   localparam logic [3:0] IER_OFFSET = 4'h0;
   localparam logic [3:0] ACK_STATUS_OFFSET = 4'h1;

   // bit positions inside serial_bus_interrupt_enable
   localparam int TX_EMPTY_EN_BIT = 7;
   localparam int TX_END_EN_BIT = 6;
   localparam int RX_FULL_EN_BIT = 5;
   localparam int NO_ACK_EN_BIT = 4;
   localparam int STOP_EN_BIT = 3;
   localparam int ACK_JUDGE_BIT = 2;
   localparam int RX_ACK_BIT = 1;
   localparam int ACK_SEND_BIT = 0;

   // bit positions inside the acknowledge status register
   localparam int HALT_BIT = 0;
   localparam int LAST_ACK_BIT = 1;
   localparam int LAST_TX_BIT = 2;

   // values after reset
   localparam logic [7:0] IER_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // bits of the enable register that software may write
   localparam logic [7:0] IER_WRITE_MASK = 8'hfd;

   // status flags from the rest of the unit, all on clock
   typedef struct packed {
      logic tx_empty_flag;
      logic tx_end_flag;
      logic rx_full_flag;
      logic no_ack_flag;
      logic arbitration_lost_flag;
      logic overrun_flag;
      logic stop_flag;
   } i2cie_flags_t;

   // interrupt request lines
   typedef struct packed {
      logic tx_empty_irq;
      logic tx_end_irq;
      logic rx_full_irq;
      logic error_irq;
      logic no_ack_irq;
      logic stop_detect_irq;
   } i2cie_irq_t;

   // one register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } i2cie_req_t;

   // acknowledge word passed from the link domain
   typedef struct packed {
      logic ack_value;
      logic tx_mode;
   } i2cie_ack_t;

endpackage : i2cie_pkg
